// ---- pkg/ciu_pkg.sv ----
// Purpose: constants and carriers for the cpu interrupt handling unit
// Assumes: 8 request sources, 13-bit program counter, wishbone data 32
// Notes: vector slots are two words apart, reset at slot zero
// Operation
// - reset and each source get own vector, low program memory by default.
// - a source is taken only with its enable and global enable both one.
// - simultaneous requests: lower vector address wins; reset first, then source zero.
// - select bit moves vectors to boot start; boot fuse moves reset vector.
// - boot lock bits suppress interrupts depending on program counter region.
// - accepting clears global enable; software may set it again for nesting.
// - return-from-interrupt sets global enable.
// - flag-type source flag cleared by hardware when vectored.
// - writing one to a flag clears it; zero leaves it.
// - flag sets even when source disabled, held until serviced or cleared.
// - flags held while global enable clear, then served by priority.
// - level sources request only while condition persists.
// - after return one main instruction runs before any interrupt.
// - clear-global-enable acts at once, even against same-cycle requests.
// - after set-global-enable the next instruction runs first.
// - entry takes four cycles pushing the program counter.
// - requests during multi-cycle instruction wait for its completion.
// - waking from sleep adds four cycles to entry.
// - return takes four cycles: pop two bytes, stack pointer plus two, set enable.
// - global enable sits in control register bit 7.
// - interrupt push lowers stack pointer by two; stack grows down.
package ciu_pkg;
	localparam int NSRC = 8;
	localparam int PCW = 13;
	// which sources are level type (no flag)
	localparam logic [7:0] LEVEL_MASK = 8'hc0;
	localparam logic [12:0] BOOT_START = 13'h1c00;
	localparam logic [12:0] VEC_STEP = 13'h0002;
	localparam logic [12:0] APP_BASE = 13'h0000;
	// wishbone byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ENABLE = 8'h04;
	localparam logic [7:0] OFF_FLAG = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_SP = 8'h10;
	// control register bits
	localparam int B_VSEL = 0;
	localparam int B_LOCK_APP = 1;
	localparam int B_LOCK_BOOT = 2;
	localparam int B_BOOT_FUSE = 3;
	localparam int B_GIE = 7;
	localparam logic [15:0] SP_RESET = 16'h0000;
	// cycle counts of each sequence
	localparam int ENTRY_CYC = 4;
	localparam int WAKE_CYC = 4;
	localparam int RETURN_FROM_IRQ_INSTR_CYC = 4;
	localparam logic [1:0] ENTRY_LAST = 2'(ENTRY_CYC - 1);
	localparam logic [1:0] WAKE_LAST = 2'(WAKE_CYC - 1);
	localparam logic [1:0] RETURN_FROM_IRQ_INSTR_LAST = 2'(RETURN_FROM_IRQ_INSTR_CYC - 1);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAKE = 2'b01,
		ST_ENTRY = 2'b10,
		ST_RETURN_FROM_IRQ_INSTR = 2'b11
	} ciu_state_t;

	// per-cycle information from the pipeline
	typedef struct packed {
		logic instr_done;
		logic is_cli;
		logic is_sei;
		logic is_return_from_irq_instr;
		logic asleep;
		logic [12:0] pc;
	} ciu_pipe_t;

	// stack memory request
	typedef struct packed {
		logic we;
		logic re;
		logic [15:0] addr;
		logic [7:0] wdata;
	} ciu_mem_t;
endpackage

// ---- design/ciu_top.sv ----
// Purpose: interrupt and reset vectoring beside an 8-bit cpu pipeline
// Assumes: stack read data arrives one cycle after the read request
// Notes: wishbone classic slave, one wait state, all outputs registered
`timescale 1ns/100ps
`default_nettype none
module ciu_top
	import ciu_pkg::*;
(
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire ciu_pipe_t pipe_in,
	input wire logic [7:0] src_event_in,
	input wire logic [7:0] src_level_in,
	input wire logic [7:0] mem_rdata_in,
	output ciu_mem_t mem_out,
	output logic stall_out,
	output logic irq_take_out,
	output logic [12:0] irq_vec_out,
	output logic pc_load_out,
	output logic [12:0] pc_target_out,
	output logic [12:0] reset_vector_out,
	output logic global_en_out,
	output logic wake_out
);

	typedef struct packed {
		ciu_state_t state;
		logic [1:0] cnt;
		logic gie;
		logic [3:0] ctrl;
		logic [7:0] enable;
		logic [7:0] flag;
		logic [15:0] sp;
		logic [12:0] ret_pc;
		logic [12:0] vec;
		logic ack;
		logic [31:0] rdata;
		ciu_mem_t mem;
		logic stall;
		logic take;
		logic pc_load;
		logic [12:0] pc_target;
		logic [12:0] rst_vec;
		logic wake;
	} ciu_regs_t;

	logic rst_meta_reg;
	logic rst_sync_reg;
	ciu_regs_t r_reg;
	ciu_regs_t r_next;

	// lowest index with a request, which is the lowest vector address
	function automatic logic [2:0] pick_first(input logic [7:0] req);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction

	// merge written bytes under the byte enables
	function automatic logic [31:0] lane_merge(input logic [31:0] old,
		input logic [31:0] wr, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = wr[8*b +: 8];
			end
		end
		return res;
	endfunction

	// reset release through two flops
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	logic [7:0] pending;
	logic [7:0] armed;
	logic [2:0] win;
	logic [12:0] vec_base;
	logic [12:0] win_vec;
	logic pc_in_boot;
	logic locked;
	logic boundary;
	logic accept;
	logic bus_req;
	logic bus_wr;
	logic [31:0] ctrl_word;
	logic [31:0] wmerge;

	// request qualification and arbitration
	always_comb begin
		// flag sources from held flags, level sources only while present
		pending = (r_reg.flag & ~LEVEL_MASK)
			| (src_level_in & LEVEL_MASK);
		armed = pending & r_reg.enable;
		win = pick_first(armed);
		vec_base = r_reg.ctrl[B_VSEL] ? BOOT_START : APP_BASE;
		// slot zero is reset, sources follow in order
		win_vec = vec_base + VEC_STEP * (13'(win) + 13'h0001);
		pc_in_boot = pipe_in.pc >= BOOT_START;
		// a lock stops vectoring into the other section
		locked = (r_reg.ctrl[B_LOCK_APP] && !r_reg.ctrl[B_VSEL]
			&& pc_in_boot)
			|| (r_reg.ctrl[B_LOCK_BOOT] && r_reg.ctrl[B_VSEL]
			&& !pc_in_boot);
		// only at the end of a whole instruction, or while asleep
		boundary = pipe_in.instr_done || pipe_in.asleep;
		accept = (r_reg.state == ST_IDLE) && boundary && r_reg.gie
			&& (armed != 8'h00) && !locked
			&& !pipe_in.is_cli
			&& !pipe_in.is_sei
			&& !pipe_in.is_return_from_irq_instr;
	end

	// bus decode helpers
	always_comb begin
		bus_req = wb_cyc_in && wb_stb_in && !r_reg.ack;
		bus_wr = bus_req && wb_we_in;
		ctrl_word = 32'h0000_0000;
		ctrl_word[B_GIE] = r_reg.gie;
		ctrl_word[3:0] = r_reg.ctrl;
		case (wb_adr_in)
			OFF_CTRL: wmerge = lane_merge(ctrl_word, wb_dat_in, wb_sel_in);
			OFF_ENABLE: wmerge = lane_merge({24'h0, r_reg.enable},
				wb_dat_in, wb_sel_in);
			OFF_SP: wmerge = lane_merge({16'h0, r_reg.sp},
				wb_dat_in, wb_sel_in);
			default: wmerge = wb_dat_in & {{24{1'b0}}, {8{wb_sel_in[0]}}};
		endcase
	end

	// next state of the whole block
	always_comb begin
		r_next = r_reg;
		r_next.ack = bus_req;
		r_next.take = 1'b0;
		r_next.pc_load = 1'b0;
		r_next.wake = 1'b0;
		r_next.mem.we = 1'b0;
		r_next.mem.re = 1'b0;
		r_next.rst_vec = r_reg.ctrl[B_BOOT_FUSE] ? BOOT_START
			: APP_BASE;

		// register writes from software
		if (bus_wr) begin
			case (wb_adr_in)
				OFF_CTRL: begin
					r_next.ctrl = wmerge[3:0];
					r_next.gie = wmerge[B_GIE];
				end
				OFF_ENABLE: r_next.enable = wmerge[7:0];
				OFF_FLAG: r_next.flag = r_reg.flag & ~wmerge[7:0];
				OFF_SP: r_next.sp = wmerge[15:0];
				default: r_next.ctrl = r_reg.ctrl;
			endcase
		end

		// global enable from pipeline instructions
		if (pipe_in.instr_done && pipe_in.is_cli) begin
			r_next.gie = 1'b0;
		end
		if (pipe_in.instr_done && pipe_in.is_sei) begin
			r_next.gie = 1'b1;
		end

		// sequencer
		case (r_reg.state)
			ST_IDLE: begin
				r_next.cnt = 2'h0;
				if (accept) begin
					r_next.gie = 1'b0;
					r_next.take = 1'b1;
					r_next.vec = win_vec;
					r_next.ret_pc = pipe_in.pc;
					r_next.stall = 1'b1;
					r_next.wake = pipe_in.asleep;
					r_next.state = pipe_in.asleep ? ST_WAKE
						: ST_ENTRY;
					if (!LEVEL_MASK[win]) begin
						r_next.flag[win] = 1'b0;
					end
				end else if (pipe_in.instr_done && pipe_in.is_return_from_irq_instr) begin
					r_next.stall = 1'b1;
					r_next.state = ST_RETURN_FROM_IRQ_INSTR;
				end
			end
			ST_WAKE: begin
				// extra cycles on top of the sleep start-up
				r_next.cnt = r_reg.cnt + 2'h1;
				if (r_reg.cnt == WAKE_LAST) begin
					r_next.cnt = 2'h0;
					r_next.state = ST_ENTRY;
				end
			end
			ST_ENTRY: begin
				r_next.cnt = r_reg.cnt + 2'h1;
				// low byte first, then high, each one below the last
				if (r_reg.cnt == 2'h0) begin
					r_next.mem.we = 1'b1;
					r_next.mem.addr = r_reg.sp;
					r_next.mem.wdata = r_reg.ret_pc[7:0];
					r_next.sp = r_reg.sp - 16'h0001;
				end else if (r_reg.cnt == 2'h1) begin
					r_next.mem.we = 1'b1;
					r_next.mem.addr = r_reg.sp;
					r_next.mem.wdata = {3'h0, r_reg.ret_pc[12:8]};
					r_next.sp = r_reg.sp - 16'h0001;
				end
				if (r_reg.cnt == ENTRY_LAST) begin
					r_next.pc_load = 1'b1;
					r_next.pc_target = r_reg.vec;
					r_next.stall = 1'b0;
					r_next.state = ST_IDLE;
				end
			end
			ST_RETURN_FROM_IRQ_INSTR: begin
				r_next.cnt = r_reg.cnt + 2'h1;
				// high byte sits on top, low byte under it
				if (r_reg.cnt == 2'h0 || r_reg.cnt == 2'h1) begin
					r_next.mem.re = 1'b1;
					r_next.mem.addr = r_reg.sp + 16'h0001;
					r_next.sp = r_reg.sp + 16'h0001;
				end
				// pop data stands the cycle after the registered read
				if (r_reg.cnt == 2'h2) begin
					r_next.ret_pc[12:8] = mem_rdata_in[4:0];
				end
				if (r_reg.cnt == RETURN_FROM_IRQ_INSTR_LAST) begin
					r_next.ret_pc[7:0] = mem_rdata_in;
					r_next.gie = 1'b1;
					r_next.pc_load = 1'b1;
					r_next.pc_target = {r_reg.ret_pc[12:8], mem_rdata_in};
					r_next.stall = 1'b0;
					r_next.state = ST_IDLE;
				end
			end
			default: begin
				r_next.state = ST_IDLE;
				r_next.stall = 1'b0;
			end
		endcase

		// new events win over any clear in the same cycle
		r_next.flag = r_next.flag | (src_event_in & ~LEVEL_MASK);

		// read data for the answer
		case (wb_adr_in)
			OFF_CTRL: r_next.rdata = ctrl_word;
			OFF_ENABLE: r_next.rdata = {24'h0, r_reg.enable};
			OFF_FLAG: r_next.rdata = {24'h0, r_reg.flag};
			OFF_STATUS: r_next.rdata = {21'h0, r_reg.state,
				r_reg.stall, armed};
			OFF_SP: r_next.rdata = {16'h0, r_reg.sp};
			default: r_next.rdata = 32'h0000_0000;
		endcase
	end

	// one register for all state
	always_ff @(posedge mclk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			r_reg <= '0;
			r_reg.state <= ST_IDLE;
			r_reg.sp <= SP_RESET;
			r_reg.rst_vec <= APP_BASE;
			r_reg.pc_target <= APP_BASE;
		end else begin
			r_reg <= r_next;
		end
	end

	// outputs straight from the register
	assign wb_dat_out = r_reg.rdata;
	assign wb_ack_out = r_reg.ack;
	assign mem_out = r_reg.mem;
	assign stall_out = r_reg.stall;
	assign irq_take_out = r_reg.take;
	assign irq_vec_out = r_reg.vec;
	assign pc_load_out = r_reg.pc_load;
	assign pc_target_out = r_reg.pc_target;
	assign reset_vector_out = r_reg.rst_vec;
	assign global_en_out = r_reg.gie;
	assign wake_out = r_reg.wake;
endmodule
`default_nettype wire

// ---- testbench/ciu_stack_model.sv ----
// Purpose: stack memory beside the pipeline
// Assumes: read data one cycle after a read request
// Notes: idle read data toggles so stale bytes never pass
`timescale 1ns/100ps
`default_nettype none
module ciu_stack_model
	import ciu_pkg::*;
(
	input wire logic mclk_in,
	input wire ciu_mem_t mem_in,
	output logic [7:0] rdata_out
);
	logic [7:0] mem_reg [256];
	initial rdata_out = 8'h5a;
	// store pushes, answer pops a cycle later
	// only the return address is stacked, status stays with software
	always @(posedge mclk_in) begin
		if (mem_in.we)
			mem_reg[mem_in.addr[7:0]] <= mem_in.wdata;
		if (mem_in.re)
			rdata_out <= mem_reg[mem_in.addr[7:0]];
		else
			rdata_out <= ~rdata_out;
	end
endmodule
`default_nettype wire

// ---- testbench/ciu_sva.sv ----
// Purpose: port checks for the interrupt unit
// Assumes: one clock, reset active low
// Notes: bound onto the top module
`timescale 1ns/100ps
`default_nettype none
module ciu_sva
	import ciu_pkg::*;
(
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire ciu_pipe_t pipe_in,
	input wire ciu_mem_t mem_out,
	input wire logic stall_out,
	input wire logic irq_take_out,
	input wire logic pc_load_out,
	input wire logic global_en_out,
	input wire logic wake_out
);
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!resetn_in);
	// entry gating and enable handling
	a_take_needs_gie: assert property (
		irq_take_out |-> $past(global_en_out)) else $error("take without gie");
	a_take_clears_gie: assert property (
		irq_take_out |-> !global_en_out) else $error("gie kept on take");
	a_take_boundary: assert property (
		irq_take_out |-> $past(pipe_in.instr_done || pipe_in.asleep))
		else $error("take inside instruction");
	a_cli_blocks: assert property (
		pipe_in.instr_done && pipe_in.is_cli |=> !irq_take_out && !global_en_out)
		else $error("take after cli");
	a_sei_defers: assert property (
		pipe_in.instr_done && pipe_in.is_sei |=> !irq_take_out)
		else $error("take right after sei");
	// sequence lengths and stack traffic
	a_entry_four: assert property (
		irq_take_out && !wake_out |-> stall_out [*4] ##1 (pc_load_out && !stall_out))
		else $error("entry length");
	a_wake_eight: assert property (
		irq_take_out && wake_out |-> ##8 pc_load_out) else $error("wake entry length");
	a_push_down: assert property (
		irq_take_out && !wake_out |=> mem_out.we ##1
		(mem_out.we && mem_out.addr == $past(mem_out.addr) - 16'h0001))
		else $error("push order");
	a_return_from_irq_instr_pops: assert property (
		pipe_in.instr_done && pipe_in.is_return_from_irq_instr && !stall_out |-> ##2 mem_out.re
		##1 mem_out.re ##2 (pc_load_out && global_en_out)) else $error("return seq");
	c_take: cover property (irq_take_out && !wake_out);
	c_wake: cover property (irq_take_out && wake_out);
	c_return_from_irq_instr: cover property (pipe_in.instr_done && pipe_in.is_return_from_irq_instr);
endmodule
bind ciu_top ciu_sva i_sva (.mclk_in, .resetn_in, .pipe_in, .mem_out,
	.stall_out, .irq_take_out, .pc_load_out, .global_en_out, .wake_out);
`default_nettype wire

// ---- testbench/tb_cpu_interrupt_handling_unit.sv ----
// Purpose: directed bench for the interrupt unit
// Assumes: pipeline ops issued only while the unit is idle
// Notes: stack bytes come from the partner model
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_interrupt_handling_unit
	import ciu_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat, bdat;
	ciu_pipe_t pipe = 18'h00123;
	logic [7:0] ev = 8'h00;
	logic [7:0] lv = 8'h00;
	logic [7:0] mrd;
	ciu_mem_t mem;
	logic ack, take, load, gie, wake, stall;
	logic [12:0] vec, tgt, rvec;
	int err_total = 0;
	int compares = 0;
	// clock and instances
	always #4 clk = ~clk;
	ciu_top i_dut (.mclk_in(clk), .resetn_in(rst_n), .wb_cyc_in(cyc),
		.wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf),
		.wb_dat_in(wdat), .wb_dat_out(bdat), .wb_ack_out(ack), .pipe_in(pipe),
		.src_event_in(ev), .src_level_in(lv), .mem_rdata_in(mrd),
		.mem_out(mem), .stall_out(stall), .irq_take_out(take),
		.irq_vec_out(vec),
		.pc_load_out(load), .pc_target_out(tgt), .reset_vector_out(rvec),
		.global_en_out(gie), .wake_out(wake));
	ciu_stack_model i_stack (.mclk_in(clk), .mem_in(mem), .rdata_out(mrd));
	// verdict and comparison helpers
	task automatic report_and_stop();
		if (err_total == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic tmo();
		err_total++;
		report_and_stop();
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			$display("ERROR %0t got %h exp %h", $time, g, e);
			err_total++;
		end
	endtask
	// one classic bus cycle, read data kept in rdat
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rdat = bdat;
		cyc <= 1'b0;
		if (n >= 20) tmo();
	endtask
	// one instruction boundary with its kind
	task automatic op(input logic c, input logic s, input logic r);
		@(posedge clk);
		pipe.instr_done <= 1'b1;
		pipe.is_cli <= c;
		pipe.is_sei <= s;
		pipe.is_return_from_irq_instr <= r;
		@(posedge clk);
		pipe.instr_done <= 1'b0;
	endtask
	// wait for take (0) or pc load (1)
	task automatic wait_on(input logic sel);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((sel ? load : take) !== 1'b1 && n < 20);
		if (n >= 20) tmo();
	endtask
	task automatic no_take(input int k);
		repeat (k) begin
			@(posedge clk);
			chk(32'(take), 32'h0);
		end
	endtask
	// reset values and reset vector placement
	task automatic t_regs();
		wb(1'b0, OFF_CTRL, 32'h0);
		chk(rdat, 32'h0);
		wb(1'b0, 8'h20, 32'h0);
		chk(rdat, 32'h0);
		chk(32'(rvec), 32'h0);
		wb(1'b1, OFF_CTRL, 32'h08);
		wb(1'b1, OFF_SP, 32'h100);
		chk(32'(rvec), 32'(BOOT_START));
	endtask
	// held flags, cli, sei, priority and entry
	task automatic t_flags();
		@(posedge clk);
		ev <= 8'h15;
		@(posedge clk);
		ev <= 8'h00;
		wb(1'b1, OFF_FLAG, 32'h10);
		wb(1'b0, OFF_FLAG, 32'h0);
		chk(rdat, 32'h05);
		wb(1'b1, OFF_ENABLE, 32'hff);
		no_take(2);
		wb(1'b1, OFF_CTRL, 32'h80);
		op(1'b1, 1'b0, 1'b0);
		no_take(1);
		chk(32'(gie), 32'h0);
		op(1'b0, 1'b1, 1'b0);
		no_take(1);
		op(1'b0, 1'b0, 1'b0);
		wait_on(1'b0);
		chk(32'(vec), 32'h002);
		chk(32'(gie), 32'h0);
		chk(32'(stall), 32'h1);
		wait_on(1'b1);
		chk(32'(tgt), 32'h002);
		chk(32'(stall), 32'h0);
		wb(1'b0, OFF_FLAG, 32'h0);
		chk(rdat, 32'h04);
		wb(1'b0, OFF_SP, 32'h0);
		chk(rdat, 32'h0fe);
	endtask
	// return, then one instruction before the next take
	task automatic t_return_from_irq_instr();
		op(1'b0, 1'b0, 1'b1);
		wait_on(1'b1);
		chk(32'(tgt), 32'h123);
		chk(32'(gie), 32'h1);
		wb(1'b0, OFF_SP, 32'h0);
		chk(rdat, 32'h100);
		no_take(2);
		op(1'b0, 1'b0, 1'b0);
		wait_on(1'b0);
		chk(32'(vec), 32'h006);
		wait_on(1'b1);
	endtask
	// level source, relocated vectors, wake from sleep
	task automatic t_level();
		wb(1'b1, OFF_ENABLE, 32'h0);
		wb(1'b1, OFF_CTRL, 32'h81);
		@(posedge clk);
		lv <= 8'h40;
		@(posedge clk);
		lv <= 8'h00;
		wb(1'b1, OFF_ENABLE, 32'h40);
		op(1'b0, 1'b0, 1'b0);
		no_take(3);
		pipe.asleep <= 1'b1;
		lv <= 8'h40;
		wait_on(1'b0);
		chk(32'(vec), 32'h1c0e);
		chk(32'(wake), 32'h1);
		wait_on(1'b1);
	endtask
	// boot lock blocks vectoring from the application section
	task automatic t_lock();
		wb(1'b1, OFF_CTRL, 32'h85);
		no_take(4);
		wb(1'b1, OFF_CTRL, 32'h81);
		wait_on(1'b0);
		chk(32'(vec), 32'h1c0e);
		wait_on(1'b1);
		pipe.asleep <= 1'b0;
		lv <= 8'h00;
	endtask
	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs();
		t_flags();
		t_return_from_irq_instr();
		t_level();
		t_lock();
		report_and_stop();
	end
endmodule
`default_nettype wire
